// File: tx_section_pkg.sv
/*
  Package for the per-channel transmit section control: channel count,
  rate codes, reset values, and the carrier structs for rail data and settings.
  Assumes a single reference clock domain; the transmit clock is sampled.
*/
package tx_section_pkg;
  localparam int NUM_CH = 3;
  localparam int SYNC_STAGES = 2;
  localparam int BUF_DEPTH = 2;
  localparam logic [0:0] ALL_ONES_RST = 1'h0;
  localparam logic [0:0] EDGE_INV_RST = 1'h0;
  localparam logic [0:0] LBO_RST = 1'h0;
  localparam logic [0:0] LBO_IGNORED_VAL = 1'h0;
  localparam logic [0:0] BUF_PTR_ONE = 1'h1;
  localparam logic [1:0] BUF_CNT_ONE = 2'h1;
  localparam logic [1:0] BUF_CNT_FULL = 2'h2;

  typedef enum logic [1:0] {
    RATE_E3 = 2'h0,
    RATE_DS3 = 2'h1,
    RATE_STS1 = 2'h2
  } line_rate_t;

  // one dual-rail symbol
  typedef struct packed {
    logic pos;
    logic neg;
  } rail_pair_t;

  // per-channel configuration straps
  typedef struct packed {
    logic send_all_ones_select;
    logic transmit_sample_edge_invert;
    logic line_build_out_select;
    line_rate_t rate;
  } chan_cfg_t;
endpackage

// File: tx_section_ctrl.sv
/*
  Transmit section control for all channels: samples dual-rail data on the
  selected edge of each channel's transmit clock, substitutes all ones on
  request, and buffers symbols in a two-entry buffer toward the line driver.
  Assumes the transmit clocks are far slower than REF_CLK (64 ns period vs
  8 ns), so edges are found by oversampling after a two-flop synchroniser.
  Assumes CFG is driven from REF_CLK logic and needs no synchroniser.
  Assumes the line side drains at least one symbol per transmit clock
  period; a symbol offered while the buffer is full is lost, not held.
  Assumes each transmit clock idles low between frames, so no false edge
  follows reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tx_section_ctrl
  import tx_section_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // per-channel configuration
  input wire chan_cfg_t [NUM_CH-1:0] CFG,
  // system side
  input wire logic [NUM_CH-1:0] TRANSMIT_CLOCK_IN,
  input wire logic [NUM_CH-1:0] TRANSMIT_POSITIVE_RAIL_DATA,
  input wire logic [NUM_CH-1:0] TRANSMIT_NEGATIVE_RAIL_DATA,
  output logic [NUM_CH-1:0] IN_READY,
  // line side
  output rail_pair_t [NUM_CH-1:0] LINE_DATA,
  output logic [NUM_CH-1:0] LINE_VALID,
  input wire logic [NUM_CH-1:0] LINE_READY,
  output logic [NUM_CH-1:0] LINE_BUILD_OUT
);

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      // two-flop synchronisers; first stage read only by second
      logic [SYNC_STAGES-1:0] clk_sync_r;
      logic [SYNC_STAGES-1:0] pos_sync_r;
      logic [SYNC_STAGES-1:0] neg_sync_r;
      logic clk_prev_r;

      // settings, edge detection and the symbol taken
      logic aones_r;
      logic inv_r;
      logic rise_seen;
      logic fall_seen;
      logic sample_edge;
      rail_pair_t raw;
      rail_pair_t sym;

      // two-entry buffer; the head doubles as the output register
      rail_pair_t buf_r [BUF_DEPTH];
      rail_pair_t second;
      logic wr_ptr_r;
      logic wr_ptr_nxt;
      logic rd_ptr_r;
      logic rd_ptr_nxt;
      logic [1:0] cnt_r;
      logic [1:0] cnt_nxt;
      logic buf_full;
      logic line_free;
      logic push;
      logic pop;

      // next values of the registered outputs
      logic valid_nxt;
      rail_pair_t data_nxt;
      logic ready_nxt;
      logic rate_is_e3;
      logic lbo_nxt;

      // link clock
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          clk_sync_r <= '0;
        end else begin
          clk_sync_r <= {clk_sync_r[0], TRANSMIT_CLOCK_IN[ch]};
        end
      end

      // positive rail
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          pos_sync_r <= '0;
        end else begin
          pos_sync_r <= {pos_sync_r[0], TRANSMIT_POSITIVE_RAIL_DATA[ch]};
        end
      end

      // negative rail
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          neg_sync_r <= '0;
        end else begin
          neg_sync_r <= {neg_sync_r[0], TRANSMIT_NEGATIVE_RAIL_DATA[ch]};
        end
      end

      // previous level of the synchronised clock
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          clk_prev_r <= 1'h0;
        end else begin
          clk_prev_r <= clk_sync_r[SYNC_STAGES-1];
        end
      end

      // settings registered so mid-symbol changes act on whole symbols
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          aones_r <= ALL_ONES_RST;
        end else begin
          aones_r <= CFG[ch].send_all_ones_select;
        end
      end

      // edge choice held per channel
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          inv_r <= EDGE_INV_RST;
        end else begin
          inv_r <= CFG[ch].transmit_sample_edge_invert;
        end
      end

      // edges from the last stage only; prev resets to the idle low level
      assign rise_seen = clk_sync_r[SYNC_STAGES-1] & ~clk_prev_r;
      assign fall_seen = ~clk_sync_r[SYNC_STAGES-1] & clk_prev_r;

      always_comb begin
        case (inv_r)
          1'h1: begin
            sample_edge = rise_seen;
          end
          default: begin
            sample_edge = fall_seen;
          end
        endcase
      end

      // data synchronised alongside clock so the pair stays aligned
      assign raw = '{pos: pos_sync_r[SYNC_STAGES-1], neg: neg_sync_r[SYNC_STAGES-1]};

      always_comb begin
        case (aones_r)
          1'h1: begin
            sym = '{pos: 1'h1, neg: 1'h1};
          end
          default: begin
            sym = raw;
          end
        endcase
      end

      // a symbol arriving while full is dropped; IN_READY warns the framer
      assign buf_full = (cnt_r == BUF_CNT_FULL);
      assign push = sample_edge && !buf_full;
      assign pop = LINE_VALID[ch] && LINE_READY[ch];
      assign line_free = pop || !LINE_VALID[ch];
      assign second = buf_r[rd_ptr_r ^ BUF_PTR_ONE];

      // storage needs no reset; the count guards every read
      always_ff @(posedge REF_CLK) begin
        if (push) begin
          buf_r[wr_ptr_r] <= sym;
        end
      end

      // pointers toggle; depth two needs one bit
      always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        if (push) begin
          wr_ptr_nxt = wr_ptr_r ^ BUF_PTR_ONE;
        end
      end

      always_comb begin
        rd_ptr_nxt = rd_ptr_r;
        if (pop) begin
          rd_ptr_nxt = rd_ptr_r ^ BUF_PTR_ONE;
        end
      end

      // occupancy counts the output head too
      always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
          cnt_nxt = cnt_r + BUF_CNT_ONE;
        end else if (pop && !push) begin
          cnt_nxt = cnt_r - BUF_CNT_ONE;
        end
      end

      // buffer state registers
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          wr_ptr_r <= 1'h0;
        end else begin
          wr_ptr_r <= wr_ptr_nxt;
        end
      end

      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          rd_ptr_r <= 1'h0;
        end else begin
          rd_ptr_r <= rd_ptr_nxt;
        end
      end

      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end

      // head of buffer on the line; next entry or fresh symbol after a pop
      always_comb begin
        valid_nxt = LINE_VALID[ch];
        if (pop) begin
          valid_nxt = buf_full || push;
        end else if (push) begin
          valid_nxt = 1'h1;
        end
      end

      always_comb begin
        data_nxt = LINE_DATA[ch];
        if (pop && buf_full) begin
          data_nxt = second;
        end else if (push && line_free) begin
          data_nxt = sym;
        end
      end

      // ready drops on the same edge as the buffer filling
      assign ready_nxt = !(cnt_nxt == BUF_CNT_FULL);

      // registered outputs, all cleared in reset
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          LINE_DATA[ch] <= '0;
        end else begin
          LINE_DATA[ch] <= data_nxt;
        end
      end

      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          LINE_VALID[ch] <= 1'h0;
        end else begin
          LINE_VALID[ch] <= valid_nxt;
        end
      end

      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          IN_READY[ch] <= 1'h0;
        end else begin
          IN_READY[ch] <= ready_nxt;
        end
      end

      // pulse shaping is rate-dependent; E3 has one shape only
      assign rate_is_e3 = (CFG[ch].rate == RATE_E3);

      always_comb begin
        if (rate_is_e3) begin
          lbo_nxt = LBO_IGNORED_VAL;
        end else begin
          lbo_nxt = CFG[ch].line_build_out_select;
        end
      end

      // build-out follows the settings one edge later
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          LINE_BUILD_OUT[ch] <= LBO_RST;
        end else begin
          LINE_BUILD_OUT[ch] <= lbo_nxt;
        end
      end

    end
  endgenerate

endmodule
`default_nettype wire

// File: tx_section_ctrl_asserts.sv
/* checker on the ports of tx_section_ctrl
   bound from the bench top; one clock domain */
`timescale 1ns/1ps
`default_nettype none
module tx_section_ctrl_asserts
  import tx_section_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire chan_cfg_t [NUM_CH-1:0] CFG,
  input wire logic [NUM_CH-1:0] TRANSMIT_CLOCK_IN,
  input wire logic [NUM_CH-1:0] IN_READY,
  input wire rail_pair_t [NUM_CH-1:0] LINE_DATA,
  input wire logic [NUM_CH-1:0] LINE_VALID,
  input wire logic [NUM_CH-1:0] LINE_READY,
  input wire logic [NUM_CH-1:0] LINE_BUILD_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  build_out_a: assert property (##1 LINE_BUILD_OUT[0] == ($past(CFG[0].rate) == RATE_E3 ?
    LBO_IGNORED_VAL : $past(CFG[0].line_build_out_select))) else $error("build-out wrong");
  all_ones_a: assert property (CFG[0].send_all_ones_select [*6] ##1 $rose(LINE_VALID[0])
    |-> LINE_DATA[0] == 2'h3) else $error("all-ones missing");
  sample_edge_a: assert property ((CFG[0].transmit_sample_edge_invert ?
    $rose(TRANSMIT_CLOCK_IN[0]) : $fell(TRANSMIT_CLOCK_IN[0])) && !LINE_VALID[0]
    |-> ##3 LINE_VALID[0]) else $error("ch0 wrong sample edge");
  chan_edge_a: assert property ((CFG[1].transmit_sample_edge_invert ?
    $rose(TRANSMIT_CLOCK_IN[1]) : $fell(TRANSMIT_CLOCK_IN[1])) && !LINE_VALID[1]
    |-> ##3 LINE_VALID[1]) else $error("ch1 wrong sample edge");
  hold_out_a: assert property (LINE_VALID[0] && !LINE_READY[0] |=>
    LINE_VALID[0] && $stable(LINE_DATA[0])) else $error("symbol lost in stall");
  full_flag_a: assert property (!IN_READY[0] && $past(RESETN) |-> LINE_VALID[0])
    else $error("full but empty");
  reset_out_a: assert property (disable iff (1'b0) !RESETN |-> LINE_VALID == 3'h0
    && LINE_BUILD_OUT == 3'h0) else $error("outputs active in reset");
  ready_rel_a: assert property ($rose(RESETN) |=> IN_READY == 3'h7) else $error("not ready");
endmodule
`default_nettype wire

// File: tx_framer_model.sv
/* framer model for one channel: transmit clock and dual rails
   assumes the bench calls send; clock stands still between frames */
`timescale 1ns/1ps
`default_nettype none
module tx_framer_model (
  // link
  output logic clk,
  output logic pos,
  output logic neg
);
  initial {clk, pos, neg} = 3'h0;
  // launch on the edge opposite the sampling one, 64 ns a symbol
  task automatic send(input logic [7:0] p, input logic [7:0] n, input logic inv, input int cnt);
    for (int i = 7; i > 7 - cnt; i--) begin
      if (!inv) clk = 1'h1;
      {pos, neg} = {p[i], n[i]};
      #32 clk = !clk;
      #32 if (inv) clk = 1'h0;
    end
    {pos, neg} = ~{pos, neg}; // no stale level after the frame
  endtask
endmodule
`default_nettype wire

// File: tx_section_ctrl_tb_top.sv
/* bench for tx_section_ctrl: a framer model per channel,
   line side taken here; REF_CLK at 8 ns */
`timescale 1ns/1ps
`default_nettype none
module tx_section_ctrl_tb_top;
  import tx_section_pkg::*;
  logic clk;
  logic rst_n;
  chan_cfg_t [NUM_CH-1:0] cfg;
  logic [NUM_CH-1:0] tci, tpd, tnd, in_rdy, lv, lr, lbo;
  rail_pair_t [NUM_CH-1:0] ld;
  rail_pair_t got[NUM_CH][$];
  logic [7:0] pa = 8'h5a;
  logic [7:0] pb = 8'h3c;
  int bad_count = 0;
  int tests_run = 0;
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  tx_framer_model fr[NUM_CH-1:0] (.clk(tci), .pos(tpd), .neg(tnd));
  tx_section_ctrl dut (.REF_CLK(clk), .RESETN(rst_n), .CFG(cfg), .TRANSMIT_CLOCK_IN(tci),
    .TRANSMIT_POSITIVE_RAIL_DATA(tpd), .TRANSMIT_NEGATIVE_RAIL_DATA(tnd), .IN_READY(in_rdy),
    .LINE_DATA(ld), .LINE_VALID(lv), .LINE_READY(lr), .LINE_BUILD_OUT(lbo));
  always @(posedge clk) begin
    for (int c = 0; c < NUM_CH; c++) if (lv[c] && lr[c]) got[c].push_back(ld[c]);
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // all three channels at once, channel 1 on the opposite edge
  task automatic t_link(input logic inv, input logic ones);
    @(negedge clk);
    cfg[0].transmit_sample_edge_invert = inv;
    cfg[1].transmit_sample_edge_invert = !inv;
    cfg[0].send_all_ones_select = ones;
    cfg[2].transmit_sample_edge_invert = inv;
    cfg[2].send_all_ones_select = !ones;
    got[0].delete();
    got[1].delete();
    got[2].delete();
    fork
      fr[0].send(pa, pb, inv, 8);
      fr[1].send(pb, pa, !inv, 8);
      fr[2].send(pa, pb, inv, 8);
    join
    repeat (8) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      check("ch0 symbol", got[0][i], ones ? 8'h3 : {pa[7-i], pb[7-i]});
      check("ch1 symbol", got[1][i], {pb[7-i], pa[7-i]});
      check("ch2 symbol", got[2][i], !ones ? 8'h3 : {pa[7-i], pb[7-i]});
    end
    cfg[0].send_all_ones_select = 1'h0;
    cfg[2].send_all_ones_select = 1'h0;
  endtask
  // receiver stalls while three symbols arrive
  task automatic t_stall();
    got[0].delete();
    lr[0] = 1'h0;
    fr[0].send(pa, pb, cfg[0].transmit_sample_edge_invert, 3);
    repeat (8) @(negedge clk);
    check("ready when full", in_rdy[0], 8'h0);
    lr[0] = 1'h1;
    repeat (8) @(negedge clk);
    check("first after stall", got[0][0], {pa[7], pb[7]});
    check("second after stall", got[0][1], {pa[6], pb[6]});
    check("third dropped", 8'(got[0].size()), 8'h2);
  endtask
  task automatic t_bo();
    for (int r = 0; r < 3; r++) for (int b = 0; b < 2; b++) begin
      cfg[0].rate = line_rate_t'(r);
      cfg[0].line_build_out_select = b[0];
      cfg[2].rate = line_rate_t'(r);
      cfg[2].line_build_out_select = !b[0];
      repeat (2) @(negedge clk);
      check("build-out", lbo[0], (r == 0) ? 8'h0 : 8'(b));
      check("build-out ch2", lbo[2], (r == 0) ? 8'h0 : 8'(!b[0]));
    end
  endtask
  initial begin
    cfg = '0;
    lr = '1;
    rst_n = 1'h0;
    repeat (20) @(negedge clk);
    check("valid in reset", lv, 8'h0);
    rst_n = 1'h1;
    repeat (6) @(negedge clk);
    check("ready after reset", in_rdy, 8'h7);
    t_link(1'h0, 1'h0);
    t_link(1'h1, 1'h0);
    t_link(1'h0, 1'h1);
    t_stall();
    t_bo();
    results();
  end
  initial begin
    #20000;
    bad_count++;
    results();
  end
endmodule
bind tx_section_ctrl tx_section_ctrl_asserts chk (.REF_CLK(REF_CLK), .RESETN(RESETN), .CFG(CFG),
  .TRANSMIT_CLOCK_IN(TRANSMIT_CLOCK_IN), .IN_READY(IN_READY), .LINE_DATA(LINE_DATA),
  .LINE_VALID(LINE_VALID), .LINE_READY(LINE_READY), .LINE_BUILD_OUT(LINE_BUILD_OUT));
`default_nettype wire
